// >>> usart_pkg.sv
// constants, types and field layout of the serial data path
// assumes one system clock and a cpu register port of eight bits
package usart_pkg;

    // ****************************************************************
    // register addresses
    // ****************************************************************
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_CSA = 3'h1;
    localparam logic [2:0] ADDR_CSB = 3'h2;
    localparam logic [2:0] ADDR_CSC = 3'h3;
    localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
    localparam logic [2:0] ADDR_BAUD_HI = 3'h5;

    // ****************************************************************
    // bit positions
    // ****************************************************************
    localparam int A_RXC = 7;
    localparam int A_TXC = 6;
    localparam int A_DE = 5;
    localparam int A_DBL = 1;
    localparam int B_TXC_IE = 6;
    localparam int B_DE_IE = 5;
    localparam int B_RECEIVE_ENABLE = 4;
    localparam int B_TRANSMIT_ENABLE = 3;
    localparam int B_SZ2 = 2;
    localparam int B_RX9 = 1;
    localparam int B_TX9 = 0;
    localparam int C_MASTER = 7;
    localparam int C_SYNC = 6;
    localparam int C_PAR = 4;
    localparam int C_STOP2 = 3;
    localparam int C_SZ = 1;

    // ****************************************************************
    // reset values and counts
    // ****************************************************************
    localparam logic [2:0] SIZE_RST = 3'h3;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [11:0] BAUD_RST = 12'h000;
    localparam logic [3:0] OS_LAST_NORM = 4'hF;
    localparam logic [3:0] OS_LAST_DBL = 4'h7;
    localparam logic [3:0] OS_HALF_NORM = 4'h7;
    localparam logic [3:0] OS_HALF_DBL = 4'h3;
    localparam logic [3:0] RX_SH_W = 4'hA;

    typedef struct packed {
        logic master;
        logic sync;
        logic [1:0] parity;
        logic stop2;
        logic [2:0] size;
        logic dbl;
    } frame_cfg_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10,
        RX_STOP = 2'b11
    } rx_state_type;

endpackage

// >>> usart_tx_rx_datapath.sv
// serial transmit and receive data path with its cpu registers
// assumes a cpu port on SYS_CLK_I; pins arrive from outside the domain
`timescale 1ns/1ns
module usart_tx_rx_datapath
    import usart_pkg::*;
#(
    parameter int RX_DEPTH = 2
)
(
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic TX_COMPLETE_ACK_I,
    output logic DATA_EMPTY_IRQ_O,
    output logic TX_COMPLETE_IRQ_O,
    output logic SERIAL_OUT_PIN_O,
    output logic SERIAL_OUT_PIN_OE_O,
    input wire logic SERIAL_IN_PIN_I,
    output logic SERIAL_IN_OVERRIDE_O,
    input wire logic SYNC_CLOCK_PIN_I,
    output logic SYNC_CLOCK_PIN_O,
    output logic SYNC_CLOCK_PIN_OE_O
);

    // refuse fifo depths the one-bit pointers cannot serve
    generate
        if (RX_DEPTH < 1 || RX_DEPTH > 2)
        begin : g_depth_check
            $error("RX_DEPTH must be 1 or 2");
        end
    endgenerate

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // data bits per character code
    function automatic logic [3:0] data_bits(input logic [2:0] size);
        case (size)
            3'h0: data_bits = 4'h5;
            3'h1: data_bits = 4'h6;
            3'h2: data_bits = 4'h7;
            3'h7: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction

    // keep only the character's own bits
    function automatic logic [8:0] char_mask(input logic [8:0] d,
                                             input logic [3:0] n);
        char_mask = d & (9'h1FF >> (4'h9 - n));
    endfunction

    // whole frame, lsb leaves first
    function automatic logic [12:0] build_frame(input logic [8:0] d,
                                                input frame_cfg_type c);
        logic [12:0] f;
        logic [3:0] n;
        logic p;
        n = data_bits(c.size);
        f = 13'h1FFE;
        p = c.parity[0];
        for (int i = 0; i < 9; i++)
        begin
            if (4'(i) < n)
            begin
                f[i + 1] = d[i];
                p = p ^ d[i];
            end
        end
        if (c.parity[1])
        begin
            f[n + 4'h1] = p;
        end
        build_frame = f;
    endfunction

    // bits in a frame including start and stops
    function automatic logic [3:0] frame_len(input frame_cfg_type c);
        frame_len = 4'h2 + data_bits(c.size) + {3'h0, c.parity[1]}
            + {3'h0, c.stop2};
    endfunction

    // ****************************************************************
    // control registers
    // ****************************************************************
    frame_cfg_type cfg_reg;
    logic tx_enable_reg;
    logic receive_enable_reg;
    logic tx_ninth_bit_reg;
    logic de_irq_enable_reg;
    logic txc_irq_enable_reg;
    logic [11:0] baud_reg;
    logic wr_data;
    logic rd_data;

    assign wr_data = WR_I && ADDR_I == ADDR_DATA;
    assign rd_data = RD_I && ADDR_I == ADDR_DATA;

    // software writes to control and baud
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            cfg_reg <= '{master: 1'b0, sync: 1'b0, parity: 2'h0,
                         stop2: 1'b0, size: SIZE_RST, dbl: 1'b0};
            tx_enable_reg <= 1'b0;
            receive_enable_reg <= 1'b0;
            tx_ninth_bit_reg <= 1'b0;
            de_irq_enable_reg <= 1'b0;
            txc_irq_enable_reg <= 1'b0;
            baud_reg <= BAUD_RST;
        end
        else if (WR_I)
        begin
            case (ADDR_I)
                ADDR_CSA: cfg_reg.dbl <= WDATA_I[A_DBL];
                ADDR_CSB:
                begin
                    txc_irq_enable_reg <= WDATA_I[B_TXC_IE];
                    de_irq_enable_reg <= WDATA_I[B_DE_IE];
                    receive_enable_reg <= WDATA_I[B_RECEIVE_ENABLE];
                    tx_enable_reg <= WDATA_I[B_TRANSMIT_ENABLE];
                    cfg_reg.size[2] <= WDATA_I[B_SZ2];
                    tx_ninth_bit_reg <= WDATA_I[B_TX9];
                end
                ADDR_CSC:
                begin
                    cfg_reg.master <= WDATA_I[C_MASTER];
                    cfg_reg.sync <= WDATA_I[C_SYNC];
                    cfg_reg.parity <= WDATA_I[C_PAR +: 2];
                    cfg_reg.stop2 <= WDATA_I[C_STOP2];
                    cfg_reg.size[1:0] <= WDATA_I[C_SZ +: 2];
                end
                ADDR_BAUD_LO: baud_reg[7:0] <= WDATA_I;
                ADDR_BAUD_HI: baud_reg[11:8] <= WDATA_I[3:0];
                default: baud_reg <= baud_reg;
            endcase
        end
    end

    // ****************************************************************
    // bit timing and pin synchronisers
    // ****************************************************************
    logic [11:0] baud_cnt_reg;
    logic [3:0] tx_os_reg;
    logic [3:0] os_last;
    logic baud_tick;
    logic [2:0] xck_sync_reg;
    logic [1:0] rxd_sync_reg;
    logic clk_rise;
    logic clk_fall;
    logic tx_step;
    logic rx_line;

    assign baud_tick = baud_cnt_reg == 12'h000;
    assign os_last = cfg_reg.dbl ? OS_LAST_DBL : OS_LAST_NORM;
    assign rx_line = rxd_sync_reg[1];

    // own clock edges as master, pin edges after sync as slave
    assign clk_rise = cfg_reg.master ? baud_tick && !SYNC_CLOCK_PIN_O
        : xck_sync_reg[1] && !xck_sync_reg[2];
    assign clk_fall = cfg_reg.master ? baud_tick && SYNC_CLOCK_PIN_O
        : !xck_sync_reg[1] && xck_sync_reg[2];

    assign tx_step = cfg_reg.sync ? clk_rise
        : baud_tick && tx_os_reg == os_last;

    // divider reloads so one tick spans baud plus one clocks
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            baud_cnt_reg <= BAUD_RST;
            tx_os_reg <= 4'h0;
        end
        else
        begin
            baud_cnt_reg <= baud_tick ? baud_reg : baud_cnt_reg - 12'h001;
            if (baud_tick)
            begin
                tx_os_reg <= tx_os_reg == os_last ? 4'h0
                    : tx_os_reg + 4'h1;
            end
        end
    end

    // two flops before any logic; third stage only for edges
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            xck_sync_reg <= 3'h0;
            rxd_sync_reg <= 2'h3;
        end
        else
        begin
            xck_sync_reg <= {xck_sync_reg[1:0], SYNC_CLOCK_PIN_I};
            rxd_sync_reg <= {rxd_sync_reg[0], SERIAL_IN_PIN_I};
        end
    end

    // sync clock pin: driven as master, read as slave
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            SYNC_CLOCK_PIN_O <= 1'b0;
            SYNC_CLOCK_PIN_OE_O <= 1'b0;
        end
        else
        begin
            SYNC_CLOCK_PIN_OE_O <= cfg_reg.sync && cfg_reg.master;
            if (cfg_reg.sync && cfg_reg.master && baud_tick)
            begin
                SYNC_CLOCK_PIN_O <= !SYNC_CLOCK_PIN_O;
            end
        end
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    logic [8:0] tx_buf_reg;
    logic tx_full_reg;
    logic tx_busy_reg;
    logic [3:0] tx_left_reg;
    logic [12:0] tx_shift_reg;
    logic txc_flag_reg;
    logic tx_load;
    logic tx_done;
    logic [12:0] tx_frame;

    // load when idle or as the last stop bit ends
    assign tx_load = tx_step && tx_full_reg
        && (!tx_busy_reg || tx_left_reg == 4'h0);
    assign tx_done = tx_step && tx_busy_reg && tx_left_reg == 4'h0
        && !tx_full_reg;
    assign tx_frame = build_frame(tx_buf_reg, cfg_reg);

    // one character buffer; ninth bit taken at write
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            tx_buf_reg <= 9'h000;
            tx_full_reg <= 1'b0;
        end
        else
        begin
            // a write marks the buffer full even while loading
            tx_full_reg <= wr_data || (tx_full_reg && !tx_load);
            if (wr_data)
            begin
                tx_buf_reg <= {tx_ninth_bit_reg, WDATA_I};
            end
        end
    end

    // shifter: line idles high between frames
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            tx_busy_reg <= 1'b0;
            tx_left_reg <= 4'h0;
            tx_shift_reg <= 13'h1FFF;
            SERIAL_OUT_PIN_O <= 1'b1;
        end
        else if (tx_load)
        begin
            SERIAL_OUT_PIN_O <= tx_frame[0];
            tx_shift_reg <= {1'b1, tx_frame[12:1]};
            tx_left_reg <= frame_len(cfg_reg) - 4'h1;
            tx_busy_reg <= 1'b1;
        end
        else if (tx_step && tx_busy_reg && tx_left_reg != 4'h0)
        begin
            SERIAL_OUT_PIN_O <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
        end
        else if (tx_done)
        begin
            SERIAL_OUT_PIN_O <= 1'b1;
            tx_busy_reg <= 1'b0;
        end
    end

    // pin held until shifter and buffer drain
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            SERIAL_OUT_PIN_OE_O <= 1'b0;
        end
        else
        begin
            SERIAL_OUT_PIN_OE_O <= tx_enable_reg || tx_busy_reg
                || tx_full_reg;
        end
    end

    // cleared by service or a one; a new completion wins
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            txc_flag_reg <= 1'b0;
        end
        else if (tx_done)
        begin
            txc_flag_reg <= 1'b1;
        end
        else if (TX_COMPLETE_ACK_I
            || (WR_I && ADDR_I == ADDR_CSA && WDATA_I[A_TXC]))
        begin
            txc_flag_reg <= 1'b0;
        end
    end

    // level requests; global enable lives in the cpu
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            DATA_EMPTY_IRQ_O <= 1'b0;
            TX_COMPLETE_IRQ_O <= 1'b0;
        end
        else
        begin
            DATA_EMPTY_IRQ_O <= de_irq_enable_reg && !tx_full_reg;
            TX_COMPLETE_IRQ_O <= txc_irq_enable_reg && txc_flag_reg;
        end
    end

    // ****************************************************************
    // receiver
    // ****************************************************************
    rx_state_type rx_state_reg;
    logic [3:0] rx_os_reg;
    logic [3:0] rx_left_reg;
    logic [9:0] rx_shift_reg;
    logic [8:0] rx_mem_reg [RX_DEPTH];
    logic rx_wp_reg;
    logic rx_rp_reg;
    logic [1:0] rx_count_reg;
    logic rx_step;
    logic rx_mid;
    logic rx_push;
    logic rx_pop;
    logic [3:0] rx_total;
    logic [8:0] rx_char;

    // sample on the sync clock; async samples mid-bit
    assign rx_step = cfg_reg.sync ? clk_fall : baud_tick;
    assign rx_mid = cfg_reg.sync || rx_os_reg == os_last;
    assign rx_total = data_bits(cfg_reg.size) + {3'h0, cfg_reg.parity[1]};
    // upper bits forced to zero on capture
    assign rx_char = char_mask(9'(rx_shift_reg >> (RX_SH_W - rx_total)),
                               data_bits(cfg_reg.size));
    // capture on the first stop bit only
    assign rx_push = rx_step && rx_mid && rx_state_reg == RX_STOP
        && rx_count_reg != 2'(RX_DEPTH);
    assign rx_pop = rd_data && rx_count_reg != 2'h0;

    // start detect, half-bit check in async mode only, then one sample per bit
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            rx_state_reg <= RX_IDLE;
            rx_os_reg <= 4'h0;
            rx_left_reg <= 4'h0;
            rx_shift_reg <= 10'h000;
        end
        else if (!receive_enable_reg)
        begin
            rx_state_reg <= RX_IDLE;
        end
        else if (rx_step)
        begin
            rx_os_reg <= rx_os_reg + 4'h1;
            case (rx_state_reg)
                RX_IDLE:
                begin
                    rx_os_reg <= 4'h0;
                    rx_left_reg <= rx_total;
                    if (!rx_line)
                    begin
                        rx_state_reg <= cfg_reg.sync ? RX_BITS : RX_START;
                    end
                end
                RX_START:
                begin
                    if (rx_os_reg == (cfg_reg.dbl ? OS_HALF_DBL
                        : OS_HALF_NORM))
                    begin
                        rx_os_reg <= 4'h0;
                        // glitch shorter than half a bit is dropped
                        rx_state_reg <= rx_line ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS:
                begin
                    if (rx_mid)
                    begin
                        rx_os_reg <= 4'h0;
                        rx_shift_reg <= {rx_line, rx_shift_reg[9:1]};
                        rx_left_reg <= rx_left_reg - 4'h1;
                        if (rx_left_reg == 4'h1)
                        begin
                            rx_state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (rx_mid)
                    begin
                        rx_os_reg <= 4'h0;
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // RX_DEPTH-deep fifo (one or two); flushed while the receiver is off
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            rx_wp_reg <= 1'b0;
            rx_rp_reg <= 1'b0;
            rx_count_reg <= 2'h0;
            for (int i = 0; i < RX_DEPTH; i++)
            begin
                rx_mem_reg[i] <= 9'h000;
            end
        end
        else if (!receive_enable_reg)
        begin
            rx_wp_reg <= 1'b0;
            rx_rp_reg <= 1'b0;
            rx_count_reg <= 2'h0;
        end
        else
        begin
            if (rx_push)
            begin
                rx_mem_reg[rx_wp_reg] <= rx_char;
                rx_wp_reg <= RX_DEPTH == 1 ? 1'b0 : !rx_wp_reg;
            end
            if (rx_pop)
            begin
                rx_rp_reg <= RX_DEPTH == 1 ? 1'b0 : !rx_rp_reg;
            end
            rx_count_reg <= rx_count_reg + {1'b0, rx_push}
                - {1'b0, rx_pop};
        end
    end

    // receive pin taken over while enabled
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            SERIAL_IN_OVERRIDE_O <= 1'b0;
        end
        else
        begin
            SERIAL_IN_OVERRIDE_O <= receive_enable_reg;
        end
    end

    // ****************************************************************
    // register read back
    // ****************************************************************
    logic [8:0] rx_head;
    logic rx_ready;
    logic [7:0] rd_mux;

    assign rx_ready = rx_count_reg != 2'h0;
    assign rx_head = rx_ready ? rx_mem_reg[rx_rp_reg] : 9'h000;

    // live status; data empty bit is read-only
    always_comb
    begin
        rd_mux = 8'h00;
        case (ADDR_I)
            ADDR_DATA: rd_mux = rx_head[7:0];
            ADDR_CSA:
            begin
                rd_mux[A_RXC] = rx_ready;
                rd_mux[A_TXC] = txc_flag_reg;
                rd_mux[A_DE] = !tx_full_reg;
                rd_mux[A_DBL] = cfg_reg.dbl;
            end
            ADDR_CSB:
            begin
                rd_mux[B_TXC_IE] = txc_irq_enable_reg;
                rd_mux[B_DE_IE] = de_irq_enable_reg;
                rd_mux[B_RECEIVE_ENABLE] = receive_enable_reg;
                rd_mux[B_TRANSMIT_ENABLE] = tx_enable_reg;
                rd_mux[B_SZ2] = cfg_reg.size[2];
                rd_mux[B_RX9] = rx_head[8];
                rd_mux[B_TX9] = tx_ninth_bit_reg;
            end
            ADDR_CSC:
            begin
                rd_mux[C_MASTER] = cfg_reg.master;
                rd_mux[C_SYNC] = cfg_reg.sync;
                rd_mux[C_PAR +: 2] = cfg_reg.parity;
                rd_mux[C_STOP2] = cfg_reg.stop2;
                rd_mux[C_SZ +: 2] = cfg_reg.size[1:0];
            end
            ADDR_BAUD_LO: rd_mux = baud_reg[7:0];
            ADDR_BAUD_HI: rd_mux = {4'h0, baud_reg[11:8]};
            default: rd_mux = 8'h00;
        endcase
    end

    // data valid only in the cycle after the strobe
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            RDATA_O <= 8'h00;
        end
        else
        begin
            RDATA_O <= RD_I ? rd_mux : 8'h00;
        end
    end

endmodule

// >>> usart_chk.sv
// checker for the serial data path at its top ports
// assumes baud zero and asynchronous frames while they run
`timescale 1ns/1ns
module usart_chk
    import usart_pkg::*;
#(parameter int RX_DEPTH = 2)
(
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic TX_COMPLETE_ACK_I,
    input wire logic DATA_EMPTY_IRQ_O,
    input wire logic TX_COMPLETE_IRQ_O,
    input wire logic SERIAL_OUT_PIN_O,
    input wire logic SERIAL_OUT_PIN_OE_O,
    input wire logic SERIAL_IN_OVERRIDE_O
);
    // ****************************************
    // frame and bus properties
    // ****************************************
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);
    // a short glitch here would be a broken bit period
    sequence low_bit;
        !SERIAL_OUT_PIN_O [*8];
    endsequence
    sequence csb_wr;
        WR_I && ADDR_I == ADDR_CSB;
    endsequence
    AST_RDATA_IDLE: assert property (
        !$past(RD_I) |-> RDATA_O == 8'h00) else $error("read data stuck");
    AST_TX_OWN: assert property (
        (csb_wr ##0 WDATA_I[B_TRANSMIT_ENABLE]) |-> ##[1:2] SERIAL_OUT_PIN_OE_O)
        else $error("output pin not taken");
    AST_RX_OWN: assert property (
        (csb_wr ##0 WDATA_I[B_RECEIVE_ENABLE]) |-> ##[1:2] SERIAL_IN_OVERRIDE_O)
        else $error("input pin not taken");
    AST_BIT_LEN: assert property (
        $fell(SERIAL_OUT_PIN_O) |-> low_bit) else $error("bit too short");
    AST_STOP_LAST: assert property (
        $fell(SERIAL_OUT_PIN_OE_O) |-> $past(SERIAL_OUT_PIN_O))
        else $error("pin freed mid frame");
    AST_DE_DROP: assert property (
        WR_I && ADDR_I == ADDR_DATA |-> ##2 !DATA_EMPTY_IRQ_O)
        else $error("empty request kept after write");
    AST_TXC_STOP: assert property (
        $rose(TX_COMPLETE_IRQ_O) |-> $past(SERIAL_OUT_PIN_O, 2))
        else $error("complete before stop bit");
    AST_TXC_CLR: assert property (
        TX_COMPLETE_ACK_I || (WR_I && ADDR_I == ADDR_CSA && WDATA_I[A_TXC])
        |-> ##2 !TX_COMPLETE_IRQ_O) else $error("complete not cleared");
endmodule
bind usart_tx_rx_datapath usart_chk #(.RX_DEPTH(RX_DEPTH)) usart_chk_i (
    .SYS_CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .TX_COMPLETE_ACK_I, .DATA_EMPTY_IRQ_O, .TX_COMPLETE_IRQ_O,
    .SERIAL_OUT_PIN_O, .SERIAL_OUT_PIN_OE_O, .SERIAL_IN_OVERRIDE_O);

// >>> remote_node.sv
// remote serial node on the far side of the pins
// assumes an asynchronous link; it hears and echoes the line
`timescale 1ns/1ns
module remote_node
(
    input wire logic line_i,
    input wire logic line_oe_i,
    output logic line_o,
    output logic sync_clock_o
);
    // ****************************************
    // line behaviour
    // ****************************************
    // idle line high: a released line sits at the pull-up level
    assign line_o = line_oe_i ? line_i : 1'b1;
    // clock stands still, no synchronous traffic
    assign sync_clock_o = 1'b0;
endmodule

// >>> tb.sv
// self-checking bench for the serial data path
// assumes the remote node loops the output back to the input
`timescale 1ns/1ns
`define CHK(n, e, a) \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
        $display("unexpected %s exp %h got %h", n, e, a); \
        miscompares++; \
    end
module tb
    import usart_pkg::*;
    ;
    logic clk, rst_n, wr, rd, ack, sout, oe, sin, ovr, sck, de_irq, txc_irq;
    logic sck_out, sck_oe;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, got;
    int miscompares = 0;
    int samples_checked = 0;
    usart_tx_rx_datapath #(.RX_DEPTH(2)) usart_tx_rx_datapath_i (
        .SYS_CLK_I(clk), .NRST_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TX_COMPLETE_ACK_I(ack),
        .DATA_EMPTY_IRQ_O(de_irq), .TX_COMPLETE_IRQ_O(txc_irq),
        .SERIAL_OUT_PIN_O(sout), .SERIAL_OUT_PIN_OE_O(oe),
        .SERIAL_IN_PIN_I(sin), .SERIAL_IN_OVERRIDE_O(ovr),
        .SYNC_CLOCK_PIN_I(sck), .SYNC_CLOCK_PIN_O(sck_out),
        .SYNC_CLOCK_PIN_OE_O(sck_oe));
    remote_node remote_node_i (.line_i(sout), .line_oe_i(oe), .line_o(sin),
        .sync_clock_o(sck));
    // ****************************************
    // clock and bus tasks
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data only stand in the cycle after the read edge
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // polling is bounded so a dead flag ends the run
    task automatic wait_flag(input int b);
        for (int i = 0; i < 300; i++)
        begin
            rd_reg(ADDR_CSA);
            if (got[b] === 1'b1)
                return;
        end
        miscompares++;
        summarize();
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        {rst_n, wr, rd, ack, addr, wdata} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(ADDR_CSA);
        `CHK("status", 8'h20, got)
        wr_reg(3'h7, 8'hFF);
        rd_reg(3'h6);
        `CHK("unmapped", 8'h00, got)
        $display("test reset done");
        wr_reg(ADDR_CSB, 8'h38);
        repeat (2) @(posedge clk);
        #1 `CHK("empty irq", 1'b1, de_irq)
        `CHK("out pin", 1'b1, oe)
        `CHK("in pin", 1'b1, ovr)
        wr_reg(ADDR_DATA, 8'h5A);
        wait_flag(A_DE);
        wr_reg(ADDR_DATA, 8'hA5);
        rd_reg(ADDR_CSA);
        `CHK("queued", 8'h00, got)
        wait_flag(A_TXC);
        rd_reg(ADDR_CSA);
        `CHK("both sent", 8'hE0, got)
        rd_reg(ADDR_DATA);
        `CHK("first char", 8'h5A, got)
        rd_reg(ADDR_DATA);
        `CHK("second char", 8'hA5, got)
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        rd_reg(ADDR_CSA);
        `CHK("after ack", 8'h20, got)
        $display("test queued pair done");
        wr_reg(ADDR_CSB, 8'h58);
        wr_reg(ADDR_CSC, 8'h20);
        wr_reg(ADDR_DATA, 8'hF5);
        wait_flag(A_TXC);
        `CHK("txc irq", 1'b1, txc_irq)
        rd_reg(ADDR_DATA);
        `CHK("short char", 8'h15, got)
        wr_reg(ADDR_CSA, 8'h40);
        repeat (2) @(posedge clk);
        #1 `CHK("txc cleared", 1'b0, txc_irq)
        $display("test short parity frame done");
        wr_reg(ADDR_DATA, 8'h33);
        wr_reg(ADDR_CSB, 8'h10);
        #1 `CHK("pin kept", 1'b1, oe)
        wait_flag(A_TXC);
        repeat (2) @(posedge clk);
        #1 `CHK("pin freed", 1'b0, oe)
        rd_reg(ADDR_DATA);
        `CHK("last char", 8'h13, got)
        $display("test disable done");
        // double speed and nine bit characters, ninth bit goes last
        wr_reg(ADDR_CSA, 8'h42);
        wr_reg(ADDR_CSC, 8'h06);
        wr_reg(ADDR_CSB, 8'h1D);
        wr_reg(ADDR_DATA, 8'h81);
        wait_flag(A_TXC);
        rd_reg(ADDR_CSB);
        `CHK("ninth bit", 8'h1F, got)
        rd_reg(ADDR_DATA);
        `CHK("nine bit char", 8'h81, got)
        $display("test nine bit done");
        // sync master: the clock pin is driven and toggles every tick
        wr_reg(ADDR_CSC, 8'hC6);
        @(posedge clk);
        #1 got[0] = sck_out;
        @(posedge clk);
        #1 `CHK("sync clock", {~got[0], 1'b1}, {sck_out, sck_oe})
        $display("test sync clock done");
        summarize();
    end
endmodule
